// file: plf_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module plf_bridge
	import plf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH, // bytes per fifo
	parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h0A0A // arbitrary value
) (
	input wire logic clock, // core clock
	input wire logic nrst, // async reset, active low
	input wire plf_req_t host_req, // one-cycle register request
	output logic [31:0] host_rdata, // read data, valid with ack
	output logic host_ack, // access done
	input wire plf_cfg_t cfg_req, // config space request
	output logic [31:0] cfg_rdata, // config read data
	output logic cfg_ack, // config access done
	output logic [7:0] link_tx_data, // byte to link adapter
	output logic link_tx_valid, // byte offered
	input wire logic link_tx_ready, // adapter takes byte
	input wire logic [7:0] link_rx_data, // byte from link adapter
	input wire logic link_rx_valid, // byte offered
	output logic link_rx_ready, // room for byte
	output logic slot_reset, // reset to first slot and link
	output logic slot_halt, // debug halt to first slot
	input wire logic slot_error_pin, // error flag of first slot
	input wire logic link_slow_pin // select 10 Mbit/s links
);
	localparam int AVAIL_POS = 8 * int'(OFS_RX_AVAIL[1:0]) + AVAIL_BIT;
	localparam int SPACE_POS = 8 * int'(OFS_TX_SPACE[1:0]) + AVAIL_BIT;
	localparam int RST_POS = 8 * int'(OFS_MOD_RST[1:0]) + RST_BIT;
	localparam int HALT_POS = 8 * int'(OFS_MOD_HALT[1:0]) + HALT_BIT;
	localparam logic [LEVEL_W-1:0] RX_GUARD = LEVEL_W'(DEPTH - 2);

	plf_regs_t q;
	plf_regs_t d;
	logic hit;
	logic rx_pop;
	logic rx_push;
	logic tx_push;
	logic tx_pop;
	logic [7:0] tx_wbyte;
	logic [7:0] rx_rdata;
	logic [7:0] tx_rdata;
	logic rx_empty;
	logic tx_empty;
	logic tx_full;
	logic [LEVEL_W-1:0] rx_level;
	logic [LEVEL_W-1:0] tx_level;
	logic slot;

	// bytes from link to host
	plf_fifo #(.DEPTH(DEPTH)) u_rx_fifo (
		.clock(clock),
		.nrst(nrst),
		.clr(q.mrst),
		.push(rx_push),
		.wdata(link_rx_data),
		.pop(rx_pop),
		.rdata(rx_rdata),
		.empty(rx_empty),
		.full(),
		.level(rx_level)
	);

	// bytes from host to link
	plf_fifo #(.DEPTH(DEPTH)) u_tx_fifo (
		.clock(clock),
		.nrst(nrst),
		.clr(q.mrst),
		.push(tx_push),
		.wdata(tx_wbyte),
		.pop(tx_pop),
		.rdata(tx_rdata),
		.empty(tx_empty),
		.full(tx_full),
		.level(tx_level)
	);

	// byte slots at link rate
	plf_pacer u_pacer (
		.clock(clock),
		.nrst(nrst),
		.clr(q.mrst),
		.slow(q.slow_s[1]),
		.slot(slot)
	);

	// outputs straight from the state register
	assign host_rdata = q.rdat;
	assign host_ack = q.ack;
	assign cfg_rdata = q.cfg_rdat;
	assign cfg_ack = q.cfg_ack;
	assign link_tx_data = q.ltx_data;
	assign link_tx_valid = q.ltx_valid;
	assign link_rx_ready = q.lrx_ready;
	assign slot_reset = q.mrst;
	assign slot_halt = q.halt;

	assign hit = (host_req.rd || host_req.wr)
		&& (host_req.addr[31:BAR_DEC_LSB] == q.bar[31:BAR_DEC_LSB]);

	// next state of the whole block
	always_comb begin
		d = q;
		d.ack = 1'b0;
		d.cfg_ack = 1'b0;
		rx_pop = 1'b0;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		tx_wbyte = 8'h00;
		// pins pass two flops before use
		d.err_s = {q.err_s[0], slot_error_pin};
		d.slow_s = {q.slow_s[0], link_slow_pin};

		// config space: identity and base register
		if (cfg_req.rd) begin
			d.cfg_ack = 1'b1;
			d.cfg_rdat = 32'h00000000;
			if (cfg_req.idx == CFG_IDX_ID) begin
				d.cfg_rdat = {DEVICE_CODE, VENDOR_CODE};
			end else if (cfg_req.idx == CFG_IDX_BAR0) begin
				d.cfg_rdat = q.bar | BAR_IO_FLAG;
			end
		end else if (cfg_req.wr) begin
			d.cfg_ack = 1'b1;
			if (cfg_req.idx == CFG_IDX_BAR0) begin
				d.bar = {cfg_req.wdata[31:BAR_DEC_LSB], BAR_DEC_LSB'(0)};
			end
		end

		// register access sequencer, one lane per cycle, two for a read lane that pops a byte
		case (q.st)
			S_IDLE: begin
				if (hit) begin
					d.idx = host_req.addr[4:2];
					d.be = host_req.be;
					d.op_wr = host_req.wr;
					d.wdat = host_req.wdata;
					d.lane = 2'b00;
					d.rdat = 32'h00000000;
					d.mask = 4'h0;
					d.st = S_XFER;
					if (host_req.rd) begin
						case (host_req.addr[4:2])
							OFS_RX_BYTE[4:2]: begin
								d.mask = host_req.be & (4'h1 << OFS_RX_BYTE[1:0]);
								d.rdat[AVAIL_POS] = !rx_empty;
								d.rdat[SPACE_POS] = !tx_full;
							end
							OFS_RX_WIDE[4:2]: begin
								d.mask = host_req.be;
							end
							OFS_MOD_RST[4:2]: begin
								d.rdat[RST_POS] = q.err_s[1];
								d.rdat[HALT_POS] = q.halt;
							end
							OFS_RX_FILL[4:2]: begin
								d.rdat[LEVEL_W-1:0] = rx_level;
							end
							OFS_TX_FREE[4:2]: begin
								d.rdat[LEVEL_W-1:0] = LEVEL_W'(DEPTH) - tx_level;
							end
							default: begin
								d.rdat = 32'h00000000;
							end
						endcase
					end else begin
						case (host_req.addr[4:2])
							OFS_TX_BYTE[4:2]: begin
								d.mask = host_req.be & (4'h1 << OFS_TX_BYTE[1:0]);
							end
							OFS_TX_WIDE[4:2]: begin
								d.mask = host_req.be;
							end
							OFS_MOD_RST[4:2]: begin
								if (host_req.be[OFS_MOD_RST[1:0]]) begin
									d.mrst = host_req.wdata[RST_POS];
								end
								if (host_req.be[OFS_MOD_HALT[1:0]]) begin
									d.halt = host_req.wdata[HALT_POS];
								end
							end
							default: begin
								d.mask = 4'h0;
							end
						endcase
					end
				end
			end
			S_XFER: begin
				if (q.mask[q.lane]) begin
					if (!q.op_wr) begin
						if (!rx_empty) begin
							rx_pop = 1'b1;
							d.st = S_CAP;
						end
					end else if (!tx_full) begin
						tx_push = 1'b1;
						tx_wbyte = q.wdat[{q.lane, 3'b000} +: 8];
					end
				end
				if (d.st == S_XFER) begin
					d.lane = q.lane + 1'b1;
					if (q.lane == 2'b11) begin
						d.ack = 1'b1;
						d.st = S_IDLE;
					end
				end
			end
			S_CAP: begin
				d.rdat[{q.lane, 3'b000} +: 8] = rx_rdata;
				d.lane = q.lane + 1'b1;
				d.st = S_XFER;
				if (q.lane == 2'b11) begin
					d.ack = 1'b1;
					d.st = S_IDLE;
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase

		// link transmit side, one byte per slot
		if (q.ltx_valid && link_tx_ready) begin
			d.ltx_valid = 1'b0;
		end
		if (q.ltx_pend) begin
			d.ltx_data = tx_rdata;
			d.ltx_valid = 1'b1;
			d.ltx_pend = 1'b0;
		end else if (!q.ltx_valid && slot && !tx_empty && !q.mrst) begin
			tx_pop = 1'b1;
			d.ltx_pend = 1'b1;
		end
		if (q.mrst) begin
			d.ltx_valid = 1'b0;
			d.ltx_pend = 1'b0;
		end

		// link receive side, ready keeps room for one in flight
		d.lrx_ready = !q.mrst && (rx_level < RX_GUARD);
	end

	assign rx_push = link_rx_valid && q.lrx_ready && !q.mrst;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.st <= S_IDLE;
			q.mrst <= MOD_RST_RESET;
			q.halt <= MOD_HALT_RESET;
			q.bar <= BAR_RESET;
		end else begin
			q <= d;
		end
	end

	property p_mod_rst;
		@(posedge clock) disable iff (!nrst)
		(q.ack && q.op_wr && q.idx == OFS_MOD_RST[4:2] && q.be[OFS_MOD_RST[1:0]])
			|-> (slot_reset == q.wdat[RST_POS]);
	endproperty
	a_mod_rst: assert property (p_mod_rst) else $error("slot reset does not follow write");

	property p_halt;
		@(posedge clock) disable iff (!nrst)
		(q.ack && q.op_wr && q.idx == OFS_MOD_HALT[4:2] && q.be[OFS_MOD_HALT[1:0]])
			|-> (slot_halt == q.wdat[HALT_POS]);
	endproperty
	a_halt: assert property (p_halt) else $error("debug halt does not follow write");

	property p_cap_after_pop;
		@(posedge clock) disable iff (!nrst)
		(q.st == S_CAP) |-> $past(rx_pop);
	endproperty
	a_cap_after_pop: assert property (p_cap_after_pop) else $error("capture without pop");

	property p_no_empty_pop;
		@(posedge clock) disable iff (!nrst)
		rx_pop |-> !rx_empty && !q.op_wr && q.mask[q.lane];
	endproperty
	a_no_empty_pop: assert property (p_no_empty_pop) else $error("pop from empty fifo");

	property p_wide_ack;
		@(posedge clock) disable iff (!nrst)
		(q.st == S_IDLE && hit && host_req.rd && host_req.addr[4:2] == OFS_RX_WIDE[4:2])
			|-> ##[5:9] q.ack;
	endproperty
	a_wide_ack: assert property (p_wide_ack) else $error("wide read not answered in time");

	property p_tx_lane;
		@(posedge clock) disable iff (!nrst)
		tx_push |-> q.op_wr && q.mask[q.lane] && (tx_wbyte == q.wdat[{q.lane, 3'b000} +: 8]);
	endproperty
	a_tx_lane: assert property (p_tx_lane) else $error("tx byte from wrong lane");
endmodule // plf_bridge
`default_nettype wire

// file: plf_bridge_tb.sv
`timescale 1ns/1ps
`default_nettype none
module plf_bridge_tb
	import plf_pkg::*;
;
	localparam int DEPTH = 8;
	localparam logic [15:0] VEN = 16'h3C3C; // arbitrary value
	localparam logic [15:0] DEV = 16'h0F0F; // arbitrary value
	logic clock = 1'b0;
	logic nrst = 1'b0;
	plf_req_t host_req = '0;
	plf_cfg_t cfg_req = '0;
	logic [31:0] host_rdata, cfg_rdata, rd;
	logic host_ack, cfg_ack, slot_reset, slot_halt;
	logic [7:0] tx_data, rx_data;
	logic tx_valid, tx_ready, rx_valid, rx_ready;
	logic err_pin = 1'b0;
	logic stall = 1'b0;
	logic slow_pin = 1'b0;
	logic [31:0] base = 32'h00000000;
	int error_cnt = 0;
	int samples_checked = 0;

	// 100 MHz core clock
	always #5 clock = ~clock;

	plf_bridge #(.DEPTH(DEPTH), .VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) uut (
		.clock(clock), .nrst(nrst), .host_req(host_req), .host_rdata(host_rdata),
		.host_ack(host_ack), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
		.link_tx_data(tx_data), .link_tx_valid(tx_valid), .link_tx_ready(tx_ready),
		.link_rx_data(rx_data), .link_rx_valid(rx_valid), .link_rx_ready(rx_ready),
		.slot_reset(slot_reset), .slot_halt(slot_halt), .slot_error_pin(err_pin),
		.link_slow_pin(slow_pin)
	);

	plf_link_model lm (
		.clock(clock), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .stall(stall)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle request pulse, then bounded wait for the ack
	task automatic acc(input logic wr, input logic [4:0] ofs, input logic [3:0] be, input logic [31:0] wd);
		int n;
		@(posedge clock);
		#1;
		host_req = '{rd: !wr, wr: wr, addr: {base[31:5], ofs}, be: be, wdata: wd};
		@(posedge clock);
		#1;
		host_req = '0;
		n = 0;
		while (n < 20 && host_ack !== 1'b1) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk({31'h0, host_ack}, 32'h1);
		rd = host_rdata;
	endtask

	task automatic cfg(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		@(posedge clock);
		#1;
		cfg_req = '{rd: !wr, wr: wr, idx: idx, wdata: wd};
		@(posedge clock);
		#1;
		cfg_req = '0;
		chk({31'h0, cfg_ack}, 32'h1);
		rd = cfg_rdata;
	endtask

	task automatic t_reset;
		chk({30'h0, slot_reset, slot_halt}, 32'h0);
		acc(1'b0, OFS_RX_FILL, 4'h3, 32'h0);
		chk(rd & 32'hFFFF, 32'h0);
		acc(1'b0, OFS_TX_FREE, 4'h3, 32'h0);
		chk(rd & 32'hFFFF, DEPTH);
		acc(1'b0, OFS_RX_BYTE, 4'hC, 32'h0);
		chk(rd & 32'h01010000, 32'h01000000);
		$display("reset test done");
	endtask

	task automatic t_cfg;
		cfg(1'b0, CFG_IDX_ID, 32'h0);
		chk(rd, {DEV, VEN});
		cfg(1'b1, CFG_IDX_BAR0, 32'h00000100);
		base = 32'h00000100;
		cfg(1'b0, CFG_IDX_BAR0, 32'h0);
		chk(rd, 32'h00000100 | BAR_IO_FLAG);
		acc(1'b0, OFS_TX_FREE, 4'h3, 32'h0);
		chk(rd & 32'hFFFF, DEPTH);
		$display("config test done");
	endtask

	task automatic t_ctrl;
		acc(1'b1, OFS_MOD_RST, 4'h1, 32'h1);
		chk({31'h0, slot_reset}, 32'h1);
		acc(1'b1, OFS_MOD_RST, 4'h2, 32'h100);
		chk({30'h0, slot_reset, slot_halt}, 32'h3);
		err_pin = 1'b1;
		repeat (4) @(posedge clock);
		acc(1'b0, OFS_MOD_RST, 4'h3, 32'h0);
		chk(rd & 32'h101, 32'h101);
		err_pin = 1'b0;
		repeat (4) @(posedge clock);
		acc(1'b0, OFS_MOD_RST, 4'h3, 32'h0);
		chk(rd & 32'h1, 32'h0);
		acc(1'b1, OFS_MOD_RST, 4'h3, 32'h0);
		chk({30'h0, slot_reset, slot_halt}, 32'h0);
		$display("control test done");
	endtask

	task automatic t_rx;
		lm.feed_q = {8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5};
		repeat (20) begin
			acc(1'b0, OFS_RX_FILL, 4'h3, 32'h0);
			if (rd[15:0] === 16'h0005)
				break;
		end
		chk(rd & 32'hFFFF, 32'h5);
		acc(1'b0, OFS_RX_BYTE, 4'h1, 32'h0);
		chk(rd & 32'hFF, 32'hA1);
		acc(1'b0, OFS_RX_WIDE, 4'hF, 32'h0);
		chk(rd, 32'hA5A4A3A2);
		acc(1'b0, OFS_RX_BYTE, 4'hD, 32'h0);
		chk(rd & 32'h000100FF, 32'h0);
		acc(1'b0, OFS_RX_FILL, 4'h3, 32'h0);
		chk(rd & 32'hFFFF, 32'h0);
		$display("receive test done");
	endtask

	task automatic t_tx;
		acc(1'b0, OFS_TX_FREE, 4'h3, 32'h0);
		stall = 1'b1;
		acc(1'b1, OFS_TX_WIDE, 4'hF, 32'h44332211);
		acc(1'b1, OFS_TX_BYTE, 4'h2, 32'h00005500);
		stall = 1'b0;
		repeat (600) if (lm.sent_q.size() < 5) @(posedge clock);
		for (int k = 0; k < 5; k++) chk({24'h0, lm.sent_q[k]}, 32'h11 * (k + 1));
		lm.sent_q = {};
		$display("transmit test done");
	endtask

	task automatic t_full;
		int n;
		stall = 1'b1;
		// park byte 0 on the held link output, so the fifo fill is known
		acc(1'b1, OFS_TX_BYTE, 4'h2, 32'h00000000);
		n = 0;
		while (n < 200 && tx_valid !== 1'b1) begin
			@(posedge clock);
			#1;
			n++;
		end
		for (int k = 0; k < 3; k++) acc(1'b1, OFS_TX_WIDE, 4'hF, 32'h04030201 + k * 32'h04040404);
		acc(1'b0, OFS_TX_FREE, 4'h3, 32'h0);
		chk(rd & 32'hFFFF, 32'h0);
		acc(1'b0, OFS_RX_BYTE, 4'hC, 32'h0);
		chk(rd & 32'h01000000, 32'h0);
		stall = 1'b0;
		repeat (1000) if (lm.sent_q.size() < DEPTH + 1) @(posedge clock);
		chk(lm.sent_q.size(), DEPTH + 1);
		for (int k = 0; k < lm.sent_q.size(); k++) chk({24'h0, lm.sent_q[k]}, k);
		acc(1'b0, OFS_TX_FREE, 4'h3, 32'h0);
		chk(rd & 32'hFFFF, DEPTH);
		acc(1'b0, OFS_RX_BYTE, 4'hC, 32'h0);
		chk(rd & 32'h01000000, 32'h01000000);
		lm.sent_q = {};
		$display("overflow test done");
	endtask

	task automatic t_rate;
		int n;
		for (int m = 0; m < 2; m++) begin
			slow_pin = (m == 1);
			repeat (300) @(posedge clock);
			#1;
			acc(1'b1, OFS_TX_WIDE, 4'h3, 32'h0000BBAA);
			n = 0;
			while (n < 400 && !(tx_valid && tx_ready)) begin
				@(posedge clock);
				#1;
				n++;
			end
			@(posedge clock);
			#1;
			n = 0;
			while (n < 400 && !(tx_valid && tx_ready)) begin
				@(posedge clock);
				#1;
				n++;
			end
			chk(n + 1, BITS_PER_BYTE * ((m == 1) ? SLOW_BIT_CYC : FAST_BIT_CYC));
			@(posedge clock);
			#1;
			chk({24'h0, lm.sent_q[0]}, 32'hAA);
			chk({24'h0, lm.sent_q[1]}, 32'hBB);
			lm.sent_q = {};
		end
		slow_pin = 1'b0;
		$display("rate test done");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog, well beyond the few thousand cycles the tests need
	initial begin
		#200_000;
		error_cnt++;
		$display("ERROR %0t: watchdog expired", $time);
		stop_test();
	end

	// reset, then the scenarios in turn
	initial begin
		repeat (12) @(posedge clock);
		#1;
		nrst = 1'b1;
		t_reset();
		t_cfg();
		t_ctrl();
		t_rx();
		t_tx();
		t_full();
		t_rate();
		stop_test();
	end
endmodule // plf_bridge_tb
`default_nettype wire

// file: plf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module plf_fifo
	import plf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clock, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic clr, // synchronous flush
	input wire logic push, // write one byte
	input wire logic [7:0] wdata, // byte to write
	input wire logic pop, // read one byte
	output logic [7:0] rdata, // byte popped last cycle
	output logic empty, // nothing held
	output logic full, // no free place
	output logic [LEVEL_W-1:0] level // bytes held
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
		logic [7:0] rdata;
	} plf_fifo_regs_t;

	plf_fifo_regs_t q;
	plf_fifo_regs_t d;
	logic do_push;
	logic do_pop;

	// flags straight from the count
	assign empty = (q.count == '0);
	assign full = (q.count == (AW + 1)'(DEPTH));
	assign level = LEVEL_W'(q.count);
	assign rdata = q.rdata;

	// push into full and pop from empty are dropped
	always_comb begin
		d = q;
		do_push = push && !full && !clr;
		do_pop = pop && !empty && !clr;
		if (do_push) begin
			d.mem[q.wptr] = wdata;
			d.wptr = q.wptr + 1'b1;
		end
		if (do_pop) begin
			d.rdata = q.mem[q.rptr];
			d.rptr = q.rptr + 1'b1;
		end
		d.count = q.count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
		if (clr) begin
			d.wptr = '0;
			d.rptr = '0;
			d.count = '0;
		end
	end

	// state register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	property p_level_inc;
		@(posedge clock) disable iff (!nrst)
		(push && !pop && !full && !clr) |=> (level == $past(level) + 1'b1);
	endproperty
	a_level_inc: assert property (p_level_inc) else $error("level did not count a push");

	property p_full_drop;
		@(posedge clock) disable iff (!nrst)
		(push && !pop && full && !clr) |=> (level == $past(level)) && full;
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("push into full fifo changed level");
endmodule // plf_fifo
`default_nettype wire

// file: plf_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// link adapter stand-in: takes tx bytes, offers rx bytes
module plf_link_model (
	input wire logic clock, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic [7:0] tx_data, // byte from bridge
	input wire logic tx_valid, // bridge offers byte
	output logic tx_ready, // byte taken
	output logic [7:0] rx_data, // byte to bridge
	output logic rx_valid, // byte offered
	input wire logic rx_ready, // bridge has room
	input wire logic stall // hold off tx and rx while high
);
	logic [7:0] sent_q[$];
	logic [7:0] feed_q[$];

	// idle rx data toggles so a stale byte never looks valid
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			if (tx_valid && tx_ready)
				sent_q.push_back(tx_data);
			tx_ready <= !stall;
			if (!rx_valid || rx_ready) begin
				if (rx_valid)
					feed_q.delete(0);
				if (feed_q.size() > 0 && !stall) begin
					rx_valid <= 1'b1;
					rx_data <= feed_q[0];
				end else begin
					rx_valid <= 1'b0;
					rx_data <= ~rx_data;
				end
			end
		end
	end
endmodule // plf_link_model
`default_nettype wire

// file: plf_pacer.sv
`timescale 1ns/1ps
`default_nettype none
module plf_pacer
	import plf_pkg::*;
(
	input wire logic clock, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic clr, // hold in restart
	input wire logic slow, // select slow link rate
	output logic slot // one pulse per byte time
);
	typedef struct packed {
		logic [15:0] per;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic slot;
	} plf_pacer_regs_t;

	plf_pacer_regs_t q;
	plf_pacer_regs_t d;
	logic [15:0] new_per;

	assign slot = q.slot;

	// count bit times, then byte times; rate is taken at byte edges
	always_comb begin
		d = q;
		d.slot = 1'b0;
		new_per = slow ? 16'(SLOW_BIT_CYC - 1) : 16'(FAST_BIT_CYC - 1);
		if (clr) begin
			d.cnt = '0;
			d.bitn = '0;
			d.per = new_per;
		end else if (q.cnt >= q.per) begin
			d.cnt = '0;
			if (q.bitn == 4'(BITS_PER_BYTE - 1)) begin
				d.bitn = '0;
				d.slot = 1'b1;
				d.per = new_per;
			end else begin
				d.bitn = q.bitn + 1'b1;
			end
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.per <= 16'(FAST_BIT_CYC - 1); // first byte at the fast link rate
		end else begin
			q <= d;
		end
	end

	property p_slot_gap;
		@(posedge clock) disable iff (!nrst)
		q.slot |=> (!q.slot) [*8];
	endproperty
	a_slot_gap: assert property (p_slot_gap) else $error("byte slots closer than link rate");
endmodule // plf_pacer
`default_nettype wire

// file: plf_pkg.sv
package plf_pkg;
	// core clock and link rates
	localparam int CLK_HZ = 100_000_000;
	localparam int LINK_FAST_BPS = 20_000_000;
	localparam int LINK_SLOW_BPS = 10_000_000;
	// bit time in core cycles, least time rounded up
	localparam int FAST_BIT_CYC = (CLK_HZ + LINK_FAST_BPS - 1) / LINK_FAST_BPS;
	localparam int SLOW_BIT_CYC = (CLK_HZ + LINK_SLOW_BPS - 1) / LINK_SLOW_BPS;
	// start, flag, eight data and stop bit per byte on the wire
	localparam int BITS_PER_BYTE = 11;
	localparam int FIFO_DEPTH = 512;
	localparam int LEVEL_W = 16;

	// register offsets from the block base
	localparam logic [4:0] OFS_RX_BYTE = 5'h00;
	localparam logic [4:0] OFS_TX_BYTE = 5'h01;
	localparam logic [4:0] OFS_RX_AVAIL = 5'h02;
	localparam logic [4:0] OFS_TX_SPACE = 5'h03;
	localparam logic [4:0] OFS_RX_WIDE = 5'h08;
	localparam logic [4:0] OFS_TX_WIDE = 5'h0C;
	localparam logic [4:0] OFS_MOD_RST = 5'h10;
	localparam logic [4:0] OFS_MOD_HALT = 5'h11;
	localparam logic [4:0] OFS_RX_FILL = 5'h18;
	localparam logic [4:0] OFS_TX_FREE = 5'h1C;

	// field positions inside their byte
	localparam int AVAIL_BIT = 0;
	localparam int RST_BIT = 0;
	localparam int HALT_BIT = 0;

	// configuration space dword indices and bar layout
	localparam logic [5:0] CFG_IDX_ID = 6'h00;
	localparam logic [5:0] CFG_IDX_BAR0 = 6'h04;
	localparam int BAR_DEC_LSB = 5;
	localparam logic [31:0] BAR_IO_FLAG = 32'h00000001;

	// reset values
	localparam logic MOD_RST_RESET = 1'b0;
	localparam logic MOD_HALT_RESET = 1'b0;
	localparam logic [31:0] BAR_RESET = 32'h00000000;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} plf_req_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] idx;
		logic [31:0] wdata;
	} plf_cfg_t;

	typedef enum logic [1:0] {S_IDLE, S_XFER, S_CAP} plf_state_t;

	typedef struct packed {
		plf_state_t st;
		logic [2:0] idx;
		logic [3:0] be;
		logic [3:0] mask;
		logic op_wr;
		logic [1:0] lane;
		logic [31:0] wdat;
		logic [31:0] rdat;
		logic ack;
		logic mrst;
		logic halt;
		logic [1:0] err_s;
		logic [1:0] slow_s;
		logic [31:0] bar;
		logic [31:0] cfg_rdat;
		logic cfg_ack;
		logic [7:0] ltx_data;
		logic ltx_valid;
		logic ltx_pend;
		logic lrx_ready;
	} plf_regs_t;
endpackage
